// [logic/acr_pkg.sv]
// shared constants for the converter control and result register block
`default_nettype none
package acr_pkg;
    // register byte addresses on the bus
    localparam logic [3:0] CONTROL_ADDR   = 4'h0;
    localparam logic [3:0] RESULT_HI_ADDR = 4'h4;
    localparam logic [3:0] RESULT_LO_ADDR = 4'h8;
    localparam logic [3:0] IRQ_STAT_ADDR  = 4'hc;
    localparam logic [3:0] IRQ_MASK_ADDR  = 4'h0;
    localparam logic [4:0] IRQ_MASK_ADDR5 = 5'h10;
    localparam logic [4:0] ADDR_WORD_HI   = 5'h10;
    // control register field positions
    localparam int JUSTIFY_BIT = 7;
    localparam int REFSEL_BIT  = 6;
    localparam int CHAN_MSB    = 4;
    localparam int CHAN_LSB    = 2;
    localparam int GO_BIT      = 1;
    localparam int ON_BIT      = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'hdf;
    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_TRIG_BIT = 1;
    localparam int IRQ_WIDTH    = 2;
    // conversion timing: fixed conversion time rounded up to whole clock cycles
    localparam int RESULT_WIDTH  = 10;
    localparam int CONV_TIME_NS  = 2000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01,
        ACR_DONE = 2'b10
    } acr_state_type;
endpackage
`default_nettype wire

// [logic/acr_justify.sv]
// justifies a 10-bit result into high and low bytes
`default_nettype none
module acr_justify (
    input  wire logic [9:0] result,
    input  wire logic       rightJustify,
    output logic      [7:0] highByte,
    output logic      [7:0] lowByte
);
    // pick byte layout from the justify select
    always_comb begin
        if (rightJustify) begin
            highByte = {6'h00, result[9:8]};
            lowByte  = result[7:0];
        end else begin
            highByte = result[9:2];
            lowByte  = {result[1:0], 6'h00};
        end
    end
endmodule
`default_nettype wire

// [logic/acr_convert.sv]
// conversion sequencer stand-in: runs a fixed number of cycles, then samples
`default_nettype none
module acr_convert (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       enable,
    input  wire logic [9:0] sample,
    output logic            busy,
    output logic            done,
    output logic      [9:0] value
);
    localparam int CW = $clog2(acr_pkg::CONV_CYCLES + 1);
    acr_pkg::acr_state_type stateQ, stateD;
    logic [CW-1:0] countQ, countD;
    logic [9:0]    valueQ, valueD;

    // next state; dropping enable aborts a running conversion
    always_comb begin
        stateD = stateQ;
        countD = countQ;
        valueD = valueQ;
        case (stateQ)
            acr_pkg::ACR_IDLE: begin
                if (start && enable) begin
                    stateD = acr_pkg::ACR_CONV;
                    countD = CW'(acr_pkg::CONV_CYCLES - 1);
                end
            end
            acr_pkg::ACR_CONV: begin
                if (!enable) begin
                    stateD = acr_pkg::ACR_IDLE;
                end else if (countQ == '0) begin
                    stateD = acr_pkg::ACR_DONE;
                    valueD = sample;
                end else begin
                    countD = countQ - 1'b1;
                end
            end
            acr_pkg::ACR_DONE: stateD = acr_pkg::ACR_IDLE;
            default:           stateD = acr_pkg::ACR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stateQ <= acr_pkg::ACR_IDLE;
            countQ <= '0;
        end else begin
            stateQ <= stateD;
            countQ <= countD;
        end
        valueQ <= valueD; // no reset: undefined until first conversion
    end

    assign busy  = (stateQ == acr_pkg::ACR_CONV);
    assign done  = (stateQ == acr_pkg::ACR_DONE);
    assign value = valueQ;
endmodule
`default_nettype wire

// [logic/acr_top.sv]
// converter control and result registers behind an axi4-lite slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`default_nettype none
module acr_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        specialTrigger,
    input  wire logic [9:0]  sampleIn,
    output logic             refSourceSel,
    output logic [2:0]       inputChannelSel,
    output logic             converterOn,
    output logic             timerClear,
    output logic             irq
);
    // control register fields
    logic       justifyQ, justifyD;
    logic       refSelQ, refSelD;
    logic [2:0] chanQ, chanD;
    logic       goQ, goD;
    logic       onQ, onD;
    logic [acr_pkg::IRQ_WIDTH-1:0] statQ, statD, maskQ, maskD;
    // bus handshake state
    logic        awHeldQ, awHeldD, wHeldQ, wHeldD;
    logic [4:0]  awAddrQ, awAddrD;
    logic [31:0] wDataQ, wDataD;
    logic [3:0]  wStrbQ, wStrbD;
    logic        bValidQ, bValidD;
    logic [1:0]  bRespQ, bRespD;
    logic        rValidQ, rValidD;
    logic [31:0] rDataQ, rDataD;
    logic [1:0]  rRespQ, rRespD;
    logic        trigSyncQ1, trigSyncQ2, trigPrevQ;
    logic [9:0]  sampleQ1, sampleQ2;
    logic        trigPulse, startConv, convBusy, convDone, doWrite;
    logic [9:0]  convValue;
    logic [7:0]  resHigh, resLow;
    logic [7:0]  ctrlRead;

    // word address decode shared by both channels
    function automatic logic [2:0] decodeAddr(input logic [4:0] a);
        if (a == acr_pkg::IRQ_MASK_ADDR5)
            return 3'h4;
        else if (a >= acr_pkg::ADDR_WORD_HI || a[1:0] != 2'h0)
            return 3'h7;
        else case (a[3:0])
            acr_pkg::CONTROL_ADDR:   return 3'h0;
            acr_pkg::RESULT_HI_ADDR: return 3'h1;
            acr_pkg::RESULT_LO_ADDR: return 3'h2;
            acr_pkg::IRQ_STAT_ADDR:  return 3'h3;
            default:                 return 3'h7;
        endcase
    endfunction

    // trigger pin and analog sample come from outside, so two stages first
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trigSyncQ1 <= 1'b0;
            trigSyncQ2 <= 1'b0;
            trigPrevQ  <= 1'b0;
        end else begin
            trigSyncQ1 <= specialTrigger;
            trigSyncQ2 <= trigSyncQ1;
            trigPrevQ  <= trigSyncQ2;
        end
        sampleQ1 <= sampleIn;
        sampleQ2 <= sampleQ1;
    end
    assign trigPulse = trigSyncQ2 && !trigPrevQ;

    acr_convert u_convert (
        .clk    (clk),
        .nrst   (nrst),
        .start  (startConv),
        .enable (onD), // same-write enable lets go and on start together
        .sample (sampleQ2),
        .busy   (convBusy),
        .done   (convDone),
        .value  (convValue)
    );

    acr_justify u_justify (
        .result       (convValue),
        .rightJustify (justifyQ),
        .highByte     (resHigh),
        .lowByte      (resLow)
    );

    assign ctrlRead = {justifyQ, refSelQ, 1'b0, chanQ, goQ, onQ};
    // built from held flags and live handshakes, never from next values: avoids a loop
    assign doWrite  = (awHeldQ || (s_axi_awvalid && s_axi_awready))
                      && (wHeldQ || (s_axi_wvalid && s_axi_wready)) && !bValidQ;

    // write channel: address and data taken in either order
    always_comb begin
        awHeldD = awHeldQ;
        wHeldD  = wHeldQ;
        awAddrD = awAddrQ;
        wDataD  = wDataQ;
        wStrbD  = wStrbQ;
        bValidD = bValidQ;
        bRespD  = bRespQ;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeldD = 1'b1;
            awAddrD = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeldD = 1'b1;
            wDataD = s_axi_wdata;
            wStrbD = s_axi_wstrb;
        end
        if (bValidQ && s_axi_bready)
            bValidD = 1'b0;
        if (doWrite) begin
            awHeldD = 1'b0;
            wHeldD  = 1'b0;
            bValidD = 1'b1;
            bRespD  = (decodeAddr(awAddrD) == 3'h7) ? acr_pkg::RESP_SLVERR : acr_pkg::RESP_OKAY;
        end
    end

    // control, go and interrupt state
    always_comb begin
        justifyD  = justifyQ;
        refSelD   = refSelQ;
        chanD     = chanQ;
        onD       = onQ;
        goD       = goQ;
        maskD     = maskQ;
        statD     = statQ;
        startConv = 1'b0;
        if (doWrite && wStrbD[0]) begin
            case (decodeAddr(awAddrD))
                3'h0: begin
                    justifyD = wDataD[acr_pkg::JUSTIFY_BIT];
                    refSelD  = wDataD[acr_pkg::REFSEL_BIT];
                    chanD    = wDataD[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB];
                    onD      = wDataD[acr_pkg::ON_BIT];
                    if (wDataD[acr_pkg::GO_BIT] && !goQ)
                        startConv = 1'b1;
                end
                3'h3: statD = statQ & ~wDataD[acr_pkg::IRQ_WIDTH-1:0];
                3'h4: maskD = wDataD[acr_pkg::IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        // hardware trigger starts a conversion just like software
        if (trigPulse && !goQ) begin
            startConv = 1'b1;
            statD[acr_pkg::IRQ_TRIG_BIT] = 1'b1;
        end
        // go only sticks when the converter is on to run it
        if (startConv && onD)
            goD = 1'b1;
        if (convDone || (goQ && !convBusy && !startConv && !onQ)) begin
            goD = 1'b0;
        end
        if (convDone)
            statD[acr_pkg::IRQ_DONE_BIT] = 1'b1;                       // set wins over clear
    end

    // read channel, one outstanding read
    always_comb begin
        rValidD = rValidQ;
        rDataD  = rDataQ;
        rRespD  = rRespQ;
        if (rValidQ && s_axi_rready)
            rValidD = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rValidD = 1'b1;
            rRespD  = acr_pkg::RESP_OKAY;
            case (decodeAddr(s_axi_araddr))
                3'h0: rDataD = {24'h000000, ctrlRead};
                3'h1: rDataD = {24'h000000, resHigh};
                3'h2: rDataD = {24'h000000, resLow};
                3'h3: rDataD = {30'h00000000, statQ};
                3'h4: rDataD = {30'h00000000, maskQ};
                default: begin
                    rDataD = 32'h00000000;
                    rRespD = acr_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // register everything; control state resets to documented zeros
    always_ff @(posedge clk) begin
        if (!nrst) begin
            justifyQ <= acr_pkg::CONTROL_RESET[acr_pkg::JUSTIFY_BIT];
            refSelQ  <= acr_pkg::CONTROL_RESET[acr_pkg::REFSEL_BIT];
            chanQ    <= acr_pkg::CONTROL_RESET[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB];
            goQ      <= acr_pkg::CONTROL_RESET[acr_pkg::GO_BIT];
            onQ      <= acr_pkg::CONTROL_RESET[acr_pkg::ON_BIT];
            statQ   <= '0;
            maskQ   <= '0;
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            awAddrQ <= '0;
            wDataQ  <= '0;
            wStrbQ  <= '0;
            bValidQ <= 1'b0;
            bRespQ  <= acr_pkg::RESP_OKAY;
            rValidQ <= 1'b0;
            rDataQ  <= '0;
            rRespQ  <= acr_pkg::RESP_OKAY;
        end else begin
            justifyQ <= justifyD;
            refSelQ  <= refSelD;
            chanQ    <= chanD;
            goQ      <= goD;
            onQ      <= onD;
            statQ    <= statD;
            maskQ    <= maskD;
            awHeldQ  <= awHeldD;
            wHeldQ   <= wHeldD;
            awAddrQ  <= awAddrD;
            wDataQ   <= wDataD;
            wStrbQ   <= wStrbD;
            bValidQ  <= bValidD;
            bRespQ   <= bRespD;
            rValidQ  <= rValidD;
            rDataQ   <= rDataD;
            rRespQ   <= rRespD;
        end
    end

    // timer clear pulse registered so it leaves a flop
    always_ff @(posedge clk) begin
        if (!nrst)
            timerClear <= 1'b0;
        else
            timerClear <= trigPulse && !goQ;
    end

    // ready only while that half of a write is not yet held
    assign s_axi_awready   = !awHeldQ && !bValidQ;
    assign s_axi_wready    = !wHeldQ && !bValidQ;
    assign s_axi_bvalid    = bValidQ;
    assign s_axi_bresp     = bRespQ;
    assign s_axi_arready   = !rValidQ;
    assign s_axi_rvalid    = rValidQ;
    assign s_axi_rdata     = rDataQ;
    assign s_axi_rresp     = rRespQ;
    assign refSourceSel    = refSelQ;
    assign inputChannelSel = chanQ;
    assign converterOn     = onQ;
    assign irq             = |(statQ & maskQ);
endmodule
`default_nettype wire

// [logic/acr_unused_none.sv]
// intentionally minimal: no further logic
`default_nettype none
`default_nettype wire

// [tb/acr_top_sva.sv]
// assertion checker for the converter control and result registers
`default_nettype none
module acr_top_sva (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [4:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        specialTrigger,
    input wire logic [9:0]  sampleIn,
    input wire logic        refSourceSel,
    input wire logic [2:0]  inputChannelSel,
    input wire logic        converterOn,
    input wire logic        timerClear,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] rdAddr_q;
    logic [2:0] chanAt_q;
    logic       refAt_q;
    logic       onAt_q;
    logic       just_q;
    logic       wrCtl;
    logic       arHit;
    logic       rdCtl;
    // aw and w are taken in one edge by this bench, so one term covers a control write
    assign wrCtl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && s_axi_awaddr == 5'h00 && s_axi_wstrb[0];
    assign arHit = s_axi_arvalid && s_axi_arready;
    assign rdCtl = s_axi_rvalid && rdAddr_q == 5'h00;
    // remember what the outstanding read refers to; read data is latched at the ar edge
    always_ff @(posedge clk) begin
        if (arHit) begin
            rdAddr_q <= s_axi_araddr;
            refAt_q  <= refSourceSel;
            chanAt_q <= inputChannelSel;
            onAt_q   <= converterOn;
        end
        if (!nrst)
            just_q <= 1'b0;
        else if (wrCtl)
            just_q <= s_axi_wdata[7];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ref_follow_a: assert property (wrCtl |=> refSourceSel == $past(s_axi_wdata[6]))
        else $error("reference select does not follow write");
    chan_follow_a: assert property (wrCtl |=> inputChannelSel == $past(s_axi_wdata[4:2]))
        else $error("input select does not follow write");
    on_follow_a: assert property (wrCtl |=> converterOn == $past(s_axi_wdata[0]))
        else $error("enable does not follow write");
    ctrl_mirror_a: assert property (rdCtl |-> s_axi_rdata[6] == refAt_q && s_axi_rdata[4:2] == chanAt_q
        && s_axi_rdata[0] == onAt_q && !s_axi_rdata[5]) else $error("control readback wrong");
    lo_left_a: assert property (s_axi_rvalid && rdAddr_q == 5'h08 && !just_q |-> s_axi_rdata[5:0] == 6'h00)
        else $error("left low byte tail not zero");
    hi_right_a: assert property (s_axi_rvalid && rdAddr_q == 5'h04 && just_q |-> s_axi_rdata[7:2] == 6'h00)
        else $error("right high byte head not zero");
    res_upper_a: assert property (s_axi_rvalid && rdAddr_q inside {5'h04, 5'h08} |-> s_axi_rdata[31:8] == 24'h0)
        else $error("result word upper bits set");
    trig_pulse_a: assert property (timerClear |=> !timerClear)
        else $error("timer clear longer than one cycle");
    read_ans_a: assert property (arHit |=> s_axi_rvalid)
        else $error("read answer late");
    unmapped_a: assert property (s_axi_rvalid && !(rdAddr_q inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10})
        |-> s_axi_rresp == acr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    // main scenarios seen
    start_c: cover property (wrCtl && s_axi_wdata[1:0] == 2'b11);
    trig_c: cover property (timerClear);
    right_c: cover property (s_axi_rvalid && rdAddr_q == 5'h04 && just_q);
endmodule
bind acr_top acr_top_sva i_sva (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .specialTrigger,
    .sampleIn, .refSourceSel, .inputChannelSel, .converterOn, .timerClear, .irq);
`default_nettype wire

// [tb/acr_top_tb.sv]
// self-checking bench for the converter control and result registers
`default_nettype none
module acr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, specialTrigger = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [9:0]  sampleIn = 10'h2a5;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        refSourceSel, converterOn, timerClear, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [2:0]  inputChannelSel;
    logic [31:0] s_axi_rdata, rd;
    int          bad_count = 0, n_compared = 0, cyc = 0, n;
    acr_top i_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .specialTrigger, .sampleIn,
        .refSourceSel, .inputChannelSel, .converterOn, .timerClear, .irq);
    // 50 MHz system clock
    always #10 clk = ~clk;
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // readies are looked at on the falling edge: they only move at rising edges
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw, w, b;
        int k;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b = 1'b0;
        for (k = 0; k < 100 && !b; k++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rdr(input logic [4:0] a);
        logic ar, r;
        int k;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        r = 1'b0;
        for (k = 0; k < 100 && !r; k++) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
    endtask
    // poll the go flag until the conversion reports finished
    task automatic wait_idle();
        int k;
        rdr(5'h00);
        for (k = 0; k < 200 && rd[1] !== 1'b0; k++) rdr(5'h00);
        chk(rd[1], 1'b0);
    endtask
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdr(5'h00); chk(rd, 32'h0);
        wr(5'h00, 32'h02); rdr(5'h00); chk(rd, 32'h0);
        for (int c = 0; c < 7; c++) for (int r = 0; r < 2; r++) begin
            wr(5'h00, {24'h0, 1'b0, r[0], 1'b1, c[2:0], 2'b01});
            rdr(5'h00); chk(rd, {24'h0, 1'b0, r[0], 1'b0, c[2:0], 2'b01});
            chk({converterOn, refSourceSel, inputChannelSel}, {1'b1, r[0], c[2:0]});
        end
        wr(5'h10, 32'h1);
        wr(5'h00, 32'h01);
        wr(5'h00, 32'h03); rdr(5'h00); chk(rd[1], 1'b1);
        wait_idle();
        rdr(5'h04); chk(rd, {24'h0, sampleIn[9:2]});
        rdr(5'h08); chk(rd, {24'h0, sampleIn[1:0], 6'h00});
        @(negedge clk); chk(irq, 1'b1);
        rdr(5'h0c); chk(rd, 32'h1);
        wr(5'h0c, 32'h1); @(negedge clk); chk(irq, 1'b0);
        wr(5'h10, 32'h0);
        sampleIn <= 10'h1c6;
        wr(5'h00, 32'h83); wait_idle();
        rdr(5'h04); chk(rd, {30'h0, sampleIn[9:8]});
        rdr(5'h08); chk(rd, {24'h0, sampleIn[7:0]});
        rdr(5'h0c); chk(rd, 32'h1); chk(irq, 1'b0);
        wr(5'h04, 32'hff); rdr(5'h04); chk(rd, {30'h0, sampleIn[9:8]});
        rdr(5'h14); chk({rs, rd[29:0]}, {acr_pkg::RESP_SLVERR, 30'h0});
        wr(5'h0c, 32'h3);
        wr(5'h00, 32'h03); wr(5'h00, 32'h00); rdr(5'h00); chk(rd, 32'h0);
        wr(5'h00, 32'h01);
        specialTrigger <= 1'b1;
        for (n = 0; n < 20 && timerClear !== 1'b1; n++) @(negedge clk);
        chk(timerClear, 1'b1);
        rdr(5'h00); chk(rd[1], 1'b1);
        specialTrigger <= 1'b0;
        rdr(5'h0c); chk(rd[1], 1'b1);
        wait_idle();
        test_done();
    end
endmodule
`default_nettype wire
